// ===== rtl/dtmf_ctrl_map.svh
// Offsets, field positions, reset values and timing counts of the
// sequence controller. Assumes inclusion by bare name from rtl/.
`ifndef DTMF_CTRL_MAP_SVH
`define DTMF_CTRL_MAP_SVH

// Clock rate and millisecond tick
`define REF_CLK_MHZ 250
`define CYCLES_PER_MS (`REF_CLK_MHZ * 1000)

// Times in milliseconds, counted on the millisecond tick
`define DIGIT_MIN_MS 14'h0032
`define GAP_MIN_MS 14'h0032
`define SEQ_TIMEOUT_MS 10000
`define ACK_TIME_MS 14'h00FA

// Register offsets (byte addresses)
`define CFG_OFFSET 8'h00
`define STATUS_OFFSET 8'h04

// Configuration register fields and reset value
`define CFG_COMMON_OFF_BIT 0
`define CFG_LEVEL_LSB 1
`define CFG_LEVEL_MSB 2
`define CFG_ACK_BOTH_BIT 3
`define CFG_WIDTH 4
`define CFG_RESET 4'h0

// Status register fields
`define STATUS_RELAY_LSB 0
`define STATUS_RELAY_MSB 10
`define STATUS_ACK_BIT 11
`define STATUS_BUSY_BIT 12
`define STATUS_HIGH_TONE_BIT 13

// Digit codes from the tone receiver
`define DIGIT_ZERO 4'h0
`define DIGIT_STAR 4'hA
`define DIGIT_HASH 4'hB

// Operation digits (second digit of a sequence)
`define OP_DISCONNECT 4'h1
`define OP_CONNECT 4'h2
`define OP_ISOLATE_ALL 4'h3

// Module positions: 0 is the common port, 1 to 10 the multiple ports
`define POSITIONS 11
`define MULTI_PORTS 10

`endif

// ===== rtl/dtmf_ctrl_pkg.sv
// Types shared by the sequence controller files.
// Assumes nothing of its surroundings.
package dtmf_ctrl_pkg;

   // Sequence walker states
   typedef enum logic [2:0] {
      SEQ_IDLE,
      SEQ_GET_OP,
      SEQ_GET_MOD,
      SEQ_SKIP_OP,
      SEQ_SKIP_MOD
   } seq_state_type;

   // Detection threshold select
   typedef enum logic [1:0] {
      LEVEL_M20,
      LEVEL_M12,
      LEVEL_M4,
      LEVEL_SPARE
   } level_sel_type;

endpackage

// ===== rtl/ms_tick_gen.sv
// Millisecond tick divider for the sequence controller.
// Assumes a free-running ref_clk and an asynchronous sys_rst.
`timescale 1ns/1ns
`default_nettype none

module ms_tick_gen #(
   parameter int unsigned CYCLES = 250000
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   output logic tick
);

   localparam logic [17:0] LAST = 18'(CYCLES - 1);

   logic [17:0] cnt_q;
   logic [17:0] cnt_d;
   logic wrap;

   // Wrap at the last cycle of each millisecond
   assign wrap = (cnt_q == LAST);
   assign cnt_d = wrap ? 18'h00000 : cnt_q + 18'h00001;

   // Divider and registered tick
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= 18'h00000;
         tick <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick <= wrap;
      end
   end

endmodule // ms_tick_gen

`default_nettype wire

// ===== rtl/dtmf_relay_test_controller.sv
// Digit sequence controller driving transfer relays of a bridge shelf.
// Assumes digits arrive decoded, synchronous to ref_clk, one strobe
// per source held for the tone, and a one-hot shelf selector strap.
//
// Summary of operation
// - Commands come only from three-digit sequences
// - Disconnect activates exactly one selected relay drive
// - Connect releases the selected relay drive
// - One sequence isolates all multiple ports
// - Shelf address from selector, digit 0 = 10
// - Act only when address digit matches shelf
// - Option ignores digits from the common port
// - Master-port indicator shows common detection active
// - Tone indicator against selected -20/-12/-4 threshold
// - Ten port indicators show isolated multiple port
// - Acknowledgement tone enabled for 0.25 seconds
// - Ack routed to bus only or bus+combiner
// - Disconnect acknowledges with 2200 Hz tone
// - Connect acknowledges with 350 Hz tone
// - Incomplete sequence after timeout returns to idle
// - Digits and pauses each at least 50 ms
// - First digit is the shelf address
// - Sequence timeout is a parameter
`timescale 1ns/1ns
`default_nettype none
`include "dtmf_ctrl_map.svh"

module dtmf_relay_test_controller #(
   parameter int unsigned MS_CYCLES = `CYCLES_PER_MS,
   parameter int unsigned SEQ_TIMEOUT_MS = `SEQ_TIMEOUT_MS
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [3:0] tab_digit,
   input wire logic tab_digit_valid,
   input wire logic [3:0] common_digit,
   input wire logic common_digit_valid,
   input wire logic [2:0] tone_above_level,
   input wire logic [9:0] shelf_select,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   output logic [10:0] relay_drive,
   output logic [9:0] port_led,
   output logic master_port_led,
   output logic tone_detected_led,
   output logic ack_tab_en,
   output logic ack_combiner_en,
   output logic ack_high_tone
);

   localparam logic [13:0] TIMEOUT_MS = 14'(SEQ_TIMEOUT_MS);

   logic ms_tick;

   // Configuration and sequence state
   logic [`CFG_WIDTH-1:0] cfg_q;
   logic [3:0] shelf_q;
   dtmf_ctrl_pkg::seq_state_type state_q;
   dtmf_ctrl_pkg::seq_state_type state_d;
   logic [3:0] op_q;
   logic [13:0] seq_ms_q;
   logic [13:0] on_ms_q;
   logic [13:0] gap_ms_q;
   logic taken_q;
   logic [13:0] ack_ms_q;

   // Millisecond time base shared by every timer
   ms_tick_gen #(
      .CYCLES(MS_CYCLES)
   ) u_tick (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .tick(ms_tick)
   );

   // Option decode
   wire common_en = ~cfg_q[`CFG_COMMON_OFF_BIT];
   wire ack_both = cfg_q[`CFG_ACK_BOTH_BIT];
   wire [1:0] level_sel = cfg_q[`CFG_LEVEL_MSB:`CFG_LEVEL_LSB];

   // Source select; the bus wins when both carry a digit
   wire common_live = common_en & common_digit_valid;
   wire digit_present = tab_digit_valid | common_live;
   wire [3:0] digit_code = tab_digit_valid ? tab_digit : common_digit;

   // Digit qualification: tone long enough after a long enough pause
   wire tone_long = (on_ms_q >= `DIGIT_MIN_MS);
   wire gap_ok = (gap_ms_q >= `GAP_MIN_MS);
   wire digit_take = digit_present & tone_long & gap_ok & ~taken_q;

   // Shelf address encoding from the one-hot selector
   logic [3:0] shelf_enc;
   always_comb begin
      shelf_enc = 4'h0;
      for (int i = 0; i < 10; i++) begin
         if (shelf_select[i]) begin
            shelf_enc = 4'(i + 1);
         end
      end
   end

   // Address digit 0 stands for shelf 10
   wire [3:0] shelf_digit = (shelf_q == 4'hA) ? `DIGIT_ZERO : shelf_q;
   wire addr_match = (shelf_q != 4'h0) && (digit_code == shelf_digit);

   // Module digit to position; star names the common port
   logic mod_ok;
   logic [3:0] mod_pos;
   always_comb begin
      mod_ok = 1'b1;
      mod_pos = digit_code;
      if (digit_code == `DIGIT_ZERO) begin
         mod_pos = 4'hA;
      end else if (digit_code == `DIGIT_STAR) begin
         mod_pos = 4'h0;
      end else if (digit_code > 4'h9) begin
         mod_ok = 1'b0;
      end
   end

   wire op_known = (digit_code == `OP_DISCONNECT) || (digit_code == `OP_CONNECT)
                   || (digit_code == `OP_ISOLATE_ALL);
   wire seq_expired = (seq_ms_q >= TIMEOUT_MS);
   wire at_third = (state_q == dtmf_ctrl_pkg::SEQ_GET_MOD) & digit_take;
   wire all_release = (op_q == `OP_CONNECT) && (digit_code == `DIGIT_HASH);
   wire do_disc = at_third & mod_ok & (op_q == `OP_DISCONNECT);
   wire do_conn = at_third & (op_q == `OP_CONNECT) & (mod_ok | all_release);
   wire do_all = at_third & (op_q == `OP_ISOLATE_ALL);
   wire cmd_done = do_disc | do_conn | do_all;

   // Relay image after the command of this cycle
   logic [10:0] relay_d;
   always_comb begin
      relay_d = relay_drive;
      if (do_disc) begin
         relay_d = 11'h000;
         relay_d[mod_pos] = 1'b1;
      end else if (do_conn && all_release) begin
         relay_d = 11'h000;
      end else if (do_conn) begin
         relay_d[mod_pos] = 1'b0;
      end else if (do_all) begin
         relay_d = {{`MULTI_PORTS{1'b1}}, 1'b0};
      end
   end

   // Sequence walker: three digits, first is the address
   always_comb begin
      state_d = state_q;
      if (state_q != dtmf_ctrl_pkg::SEQ_IDLE && seq_expired) begin
         state_d = dtmf_ctrl_pkg::SEQ_IDLE;
      end else if (digit_take) begin
         unique case (state_q)
            dtmf_ctrl_pkg::SEQ_IDLE:
               state_d = addr_match ? dtmf_ctrl_pkg::SEQ_GET_OP : dtmf_ctrl_pkg::SEQ_SKIP_OP;
            dtmf_ctrl_pkg::SEQ_GET_OP:
               state_d = op_known ? dtmf_ctrl_pkg::SEQ_GET_MOD : dtmf_ctrl_pkg::SEQ_SKIP_MOD;
            dtmf_ctrl_pkg::SEQ_GET_MOD:
               state_d = dtmf_ctrl_pkg::SEQ_IDLE;
            dtmf_ctrl_pkg::SEQ_SKIP_OP:
               state_d = dtmf_ctrl_pkg::SEQ_SKIP_MOD;
            dtmf_ctrl_pkg::SEQ_SKIP_MOD:
               state_d = dtmf_ctrl_pkg::SEQ_IDLE;
            default:
               state_d = dtmf_ctrl_pkg::SEQ_IDLE;
         endcase
      end
   end

   // Register port decode
   wire sel_cfg = (reg_addr == `CFG_OFFSET);
   wire sel_status = (reg_addr == `STATUS_OFFSET);
   wire ack_active = (ack_ms_q != 14'h0000);
   logic [31:0] status_word;
   always_comb begin
      status_word = 32'h00000000;
      status_word[`STATUS_RELAY_MSB:`STATUS_RELAY_LSB] = relay_drive;
      status_word[`STATUS_ACK_BIT] = ack_active;
      status_word[`STATUS_BUSY_BIT] = (state_q != dtmf_ctrl_pkg::SEQ_IDLE);
      status_word[`STATUS_HIGH_TONE_BIT] = ack_high_tone;
   end
   wire [31:0] rdata_d = !reg_read ? 32'h00000000 :
                         sel_cfg ? {28'h0000000, cfg_q} :
                         sel_status ? status_word : 32'h00000000;

   // Tone indicator threshold select; spare code falls back to -20
   wire tone_d = (level_sel == dtmf_ctrl_pkg::LEVEL_M12) ? tone_above_level[1] :
                 (level_sel == dtmf_ctrl_pkg::LEVEL_M4) ? tone_above_level[2] :
                 tone_above_level[0];

   // Software options and read data
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_q <= `CFG_RESET;
         reg_rdata <= 32'h00000000;
      end else begin
         if (reg_write && sel_cfg) begin
            cfg_q <= reg_wdata[`CFG_WIDTH-1:0];
         end
         reg_rdata <= rdata_d;
      end
   end

   // Strap caught by the clock, never by the reset
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shelf_q <= 4'h0;
      end else begin
         shelf_q <= shelf_enc;
      end
   end

   // Tone and pause timers on the millisecond tick; both saturate
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         on_ms_q <= 14'h0000;
         gap_ms_q <= `GAP_MIN_MS;
         taken_q <= 1'b0;
      end else begin
         if (!digit_present) begin
            on_ms_q <= 14'h0000;
            taken_q <= 1'b0;
            if (ms_tick && !gap_ok) begin
               gap_ms_q <= gap_ms_q + 14'h0001;
            end
         end else begin
            // Pause is judged when the tone qualifies, so it clears only then
            if (tone_long) begin
               gap_ms_q <= 14'h0000;
            end
            if (ms_tick && !tone_long) begin
               on_ms_q <= on_ms_q + 14'h0001;
            end
            if (digit_take) begin
               taken_q <= 1'b1;
            end
         end
      end
   end

   // Walker, sequence clock and operation digit
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= dtmf_ctrl_pkg::SEQ_IDLE;
         seq_ms_q <= 14'h0000;
         op_q <= 4'h0;
      end else begin
         state_q <= state_d;
         if (state_d == dtmf_ctrl_pkg::SEQ_IDLE) begin
            seq_ms_q <= 14'h0000;
         end else if (ms_tick) begin
            seq_ms_q <= seq_ms_q + 14'h0001;
         end
         if (state_q == dtmf_ctrl_pkg::SEQ_GET_OP && digit_take) begin
            op_q <= digit_code;
         end
      end
   end

   // Relay drive and acknowledgement; a new command restarts the tone
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         relay_drive <= 11'h000;
         ack_ms_q <= 14'h0000;
         ack_high_tone <= 1'b0;
      end else begin
         relay_drive <= relay_d;
         if (cmd_done) begin
            ack_ms_q <= `ACK_TIME_MS;
            ack_high_tone <= do_disc | do_all;
         end else if (ms_tick && ack_active) begin
            ack_ms_q <= ack_ms_q - 14'h0001;
         end
      end
   end

   // Tone enable for the next cycle: on with a command, off after the last tick
   wire ack_last = ms_tick && (ack_ms_q == 14'h0001);
   wire ack_on_d = cmd_done | (ack_active && !ack_last);

   // Front-panel indicators and tone routing enables
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         port_led <= 10'h000;
         master_port_led <= 1'b0;
         tone_detected_led <= 1'b0;
         ack_tab_en <= 1'b0;
         ack_combiner_en <= 1'b0;
      end else begin
         port_led <= relay_d[10:1];
         master_port_led <= common_en;
         tone_detected_led <= tone_d;
         ack_tab_en <= ack_on_d;
         ack_combiner_en <= ack_both & ack_on_d;
      end
   end

endmodule // dtmf_relay_test_controller

`default_nettype wire

// ===== verification/relay_ctrl_asserts.sv
// Checker of relay, acknowledgement and lamp outputs.
// Assumes it is bound onto the controller top module.
`timescale 1ns/1ns
`default_nettype none
module relay_ctrl_checker #(
   parameter int unsigned MS_CYCLES = 10
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [2:0] tone_above_level,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic [10:0] relay_drive,
   input wire logic [9:0] port_led,
   input wire logic master_port_led,
   input wire logic tone_detected_led,
   input wire logic ack_tab_en,
   input wire logic ack_combiner_en,
   input wire logic ack_high_tone
);
   // Tick phase makes the tone up to one tick short
   localparam int ACK_LO = 249 * MS_CYCLES;
   localparam int ACK_HI = 251 * MS_CYCLES;
   logic [3:0] cfg_q;
   logic [15:0] ack_cnt_q;
   wire logic [1:0] lvl;
   wire logic pick;
   // Threshold code 3 falls back to the lowest level
   assign lvl = (cfg_q[2:1] == 2'h3) ? 2'h0 : cfg_q[2:1];
   assign pick = tone_above_level[lvl];
   // Shadow of the option word and length of the tone
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_q <= 4'h0;
         ack_cnt_q <= 16'h0;
      end else begin
         if (reg_write && reg_addr == 8'h00) cfg_q <= reg_wdata[3:0];
         ack_cnt_q <= ack_tab_en ? ack_cnt_q + 16'h1 : 16'h0;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   lamp_mirror_a: assert property (port_led == relay_drive[10:1])
      else $error("port lamps differ from relays");
   ack_route_a: assert property (ack_combiner_en |-> ack_tab_en && cfg_q[3])
      else $error("combiner tone without option");
   master_lamp_a: assert property (reg_write && reg_addr == 8'h00 |-> ##2
      master_port_led == !$past(reg_wdata[0], 2)) else $error("master lamp wrong");
   tone_lamp_a: assert property (tone_detected_led == $past(pick))
      else $error("tone lamp wrong");
   ack_len_a: assert property ($fell(ack_tab_en) |-> ack_cnt_q >= ACK_LO && ack_cnt_q <= ACK_HI)
      else $error("ack tone length wrong");
   high_tone_a: assert property ($rose(ack_tab_en) && (relay_drive & ~$past(relay_drive)) != 11'h0
      |-> ack_high_tone) else $error("disconnect not at high tone");
   low_tone_a: assert property ($rose(ack_tab_en) && (relay_drive & ~$past(relay_drive)) == 11'h0 &&
      $countones(relay_drive) + 1 == $countones($past(relay_drive)) |-> !ack_high_tone)
      else $error("connect not at low tone");
   single_port_a: assert property ($rose(ack_tab_en) && ack_high_tone
      |-> $onehot(relay_drive) || relay_drive == 11'h7FE) else $error("isolation set wrong");
   quiet_relay_a: assert property (relay_drive != $past(relay_drive) |-> $rose(ack_tab_en))
      else $error("relay moved without command");
   read_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data outside slot");
   cover property ($rose(ack_tab_en) && ack_high_tone);
   cover property ($rose(ack_tab_en) && !ack_high_tone);
   cover property (relay_drive == 11'h7FE);
endmodule // relay_ctrl_checker
bind dtmf_relay_test_controller relay_ctrl_checker #(.MS_CYCLES(MS_CYCLES)) relay_ctrl_checker_i (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .tone_above_level(tone_above_level),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .relay_drive(relay_drive), .port_led(port_led),
   .master_port_led(master_port_led), .tone_detected_led(tone_detected_led),
   .ack_tab_en(ack_tab_en), .ack_combiner_en(ack_combiner_en), .ack_high_tone(ack_high_tone));
`default_nettype wire

// ===== verification/tone_receiver_model.sv
// Tone receiver standing in for the remote operator.
// Assumes the bench calls send and ref_clk runs free.
`timescale 1ns/1ns
`default_nettype none
module tone_receiver_model #(
   parameter int unsigned MS_CYCLES = 10
) (
   input wire logic ref_clk,
   output logic [3:0] tab_digit,
   output logic tab_digit_valid,
   output logic [3:0] common_digit,
   output logic common_digit_valid
);
   // Idle lines
   initial begin
      tab_digit = 4'hF;
      tab_digit_valid = 1'b0;
      common_digit = 4'hF;
      common_digit_valid = 1'b0;
   end
   // One tone, then a pause; a dead code shows the inverse, not a stale digit
   task automatic send(input logic [3:0] d, input logic src, input int tone_ms);
      @(posedge ref_clk);
      if (src) begin
         common_digit <= d;
         common_digit_valid <= 1'b1;
      end else begin
         tab_digit <= d;
         tab_digit_valid <= 1'b1;
      end
      repeat (tone_ms * MS_CYCLES) @(posedge ref_clk);
      tab_digit_valid <= 1'b0;
      common_digit_valid <= 1'b0;
      tab_digit <= ~d;
      common_digit <= ~d;
      repeat (60 * MS_CYCLES) @(posedge ref_clk);
   endtask
endmodule // tone_receiver_model
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench of the relay test controller.
// Assumes short tick and timeout parameters to keep runs brief.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam int unsigned MS = 10;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [2:0] tone_above_level = 3'h0;
   logic [9:0] shelf_select = 10'h001;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [3:0] tab_digit, common_digit;
   logic tab_digit_valid, common_digit_valid, master_port_led, tone_detected_led;
   logic ack_tab_en, ack_combiner_en, ack_high_tone;
   logic [31:0] reg_rdata;
   logic [10:0] relay_drive;
   logic [9:0] port_led;
   int fail_count = 0;
   int n_checks = 0;
   int cycles = 0;
   always #2 ref_clk = ~ref_clk;
   dtmf_relay_test_controller #(.MS_CYCLES(MS), .SEQ_TIMEOUT_MS(400)) dtmf_relay_test_controller_i (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .tab_digit(tab_digit), .tab_digit_valid(tab_digit_valid),
      .common_digit(common_digit), .common_digit_valid(common_digit_valid),
      .tone_above_level(tone_above_level), .shelf_select(shelf_select), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .relay_drive(relay_drive), .port_led(port_led), .master_port_led(master_port_led),
      .tone_detected_led(tone_detected_led), .ack_tab_en(ack_tab_en),
      .ack_combiner_en(ack_combiner_en), .ack_high_tone(ack_high_tone));
   tone_receiver_model #(.MS_CYCLES(MS)) tone_receiver_model_i (
      .ref_clk(ref_clk), .tab_digit(tab_digit), .tab_digit_valid(tab_digit_valid),
      .common_digit(common_digit), .common_digit_valid(common_digit_valid));
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1 chk(name, reg_rdata, exp);
   endtask
   task automatic dial(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c, input logic src);
      tone_receiver_model_i.send(a, src, 60);
      tone_receiver_model_i.send(b, src, 60);
      tone_receiver_model_i.send(c, src, 60);
   endtask
   task automatic outs(input logic [10:0] r, input logic a, input logic h);
      #1;
      chk("relay", 32'(relay_drive), 32'(r));
      chk("lamps", 32'(port_led), 32'(r[10:1]));
      chk("ack", 32'(ack_tab_en), 32'(a));
      chk("high", 32'(ack_high_tone), 32'(h));
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Hang guard well above the longest expected run
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fail_count++;
         conclude();
      end
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd(8'h00, 32'h0, "cfg reset");
      rd(8'h08, 32'h0, "unmapped");
      wr(8'h04, 32'hFFFF);
      rd(8'h04, 32'h0, "status ro");
      rd(8'h00, 32'h0, "cfg kept");
      // Each threshold picks its own flag; the spare code falls back to the lowest
      for (int l = 0; l < 4; l++) begin
         wr(8'h00, 32'(l) << 1);
         tone_above_level <= 3'h1 << ((l == 3) ? 0 : l);
         repeat (3) @(posedge ref_clk);
         #1 chk("tone on", 32'(tone_detected_led), 32'h1);
         @(posedge ref_clk);
         tone_above_level <= ~(3'h1 << ((l == 3) ? 0 : l));
         repeat (3) @(posedge ref_clk);
         #1 chk("tone off", 32'(tone_detected_led), 32'h0);
      end
      wr(8'h00, 32'h0);
      tone_above_level <= 3'h0;
      dial(4'h1, 4'h1, 4'h5, 1'b0);
      outs(11'h020, 1'b1, 1'b1);
      chk("comb", 32'(ack_combiner_en), 32'h0);
      rd(8'h04, 32'h2820, "status");
      dial(4'h2, 4'h1, 4'h3, 1'b0);
      outs(11'h020, 1'b0, 1'b1);
      dial(4'h1, 4'h2, 4'h5, 1'b0);
      outs(11'h000, 1'b1, 1'b0);
      wr(8'h00, 32'h8);
      dial(4'h1, 4'h3, 4'h9, 1'b0);
      outs(11'h7FE, 1'b1, 1'b1);
      chk("comb", 32'(ack_combiner_en), 32'h1);
      // Common port shut out, then let back in
      wr(8'h00, 32'h9);
      rd(8'h00, 32'h9, "cfg");
      repeat (2) @(posedge ref_clk);
      #1 chk("master", 32'(master_port_led), 32'h0);
      dial(4'h1, 4'h2, 4'h0, 1'b1);
      outs(11'h7FE, 1'b0, 1'b1);
      wr(8'h00, 32'h8);
      dial(4'h1, 4'h2, 4'h0, 1'b1);
      outs(11'h3FE, 1'b1, 1'b0);
      @(posedge ref_clk);
      shelf_select <= 10'h200;
      dial(4'h0, 4'h1, 4'hA, 1'b0);
      outs(11'h001, 1'b1, 1'b1);
      // Partial sequence left to expire
      tone_receiver_model_i.send(4'h0, 1'b0, 60);
      tone_receiver_model_i.send(4'h1, 1'b0, 60);
      rd(8'h04, 32'h3001, "busy");
      repeat (500 * MS) @(posedge ref_clk);
      rd(8'h04, 32'h2001, "expired");
      dial(4'h0, 4'h2, 4'hA, 1'b0);
      outs(11'h000, 1'b1, 1'b0);
      // A 20 ms blip must not count as a digit
      tone_receiver_model_i.send(4'h0, 1'b0, 60);
      tone_receiver_model_i.send(4'h3, 1'b0, 20);
      tone_receiver_model_i.send(4'h1, 1'b0, 60);
      tone_receiver_model_i.send(4'h5, 1'b0, 60);
      outs(11'h020, 1'b1, 1'b1);
      conclude();
   end
endmodule // tb_top
`default_nettype wire
